//--- design/rcs_pkg.sv
// Constants shared by the radio configuration serial port slave.
// Assumes a 10 MHz system clock and an AXI4-Lite master for software access.
// What this block and its host do
// RQ1: Every serial byte moves most significant bit first.
// RQ2: Header byte holds read flag, burst flag, address.
// RQ3: Host keeps select low for whole transaction.
// RQ4: Select released mid-byte aborts the transaction.
// RQ5: Host waits for serial-out low before clocking.
// RQ6: Select low with oscillator running drives serial-out low.
// RQ7: Waking from power-down keeps serial-out high until ready.
// RQ8: Blind host waits 150 us after select.
// RQ9: Reset loads every configuration register default.
// RQ10: Host rewrites non-default registers after each reset.
// RQ11: Same port writes the 64-byte transmit buffer.
// RQ12: Status byte shifts out; bit 7 flags oscillator.
// RQ13: Status bits 6..4 carry main state code.
// RQ14: Status bits 3..0 give free bytes, saturating 15.
// RQ15: Burst address counter steps after every byte.
// RQ16: Aborted access changes nothing; next byte is header.
package rcs_pkg;
  // Serial address map.
  localparam logic [5:0] CFG_LAST = 6'h2e;
  localparam logic [5:0] STROBE_FIRST = 6'h30;
  localparam logic [5:0] STROBE_LAST = 6'h3d;
  localparam logic [5:0] BUF_ADDR = 6'h3f;
  localparam int CFG_COUNT = 47;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int BUF_DEPTH = 64;
  // Header and status byte layout.
  localparam int HDR_RW = 7;
  localparam int HDR_BURST = 6;
  localparam logic [3:0] FREE_SAT = 4'hf;
  // Main state codes reported in the status byte.
  localparam logic [2:0] ST_IDLE = 3'h0;
  localparam logic [2:0] ST_TX = 3'h2;
  localparam logic [2:0] ST_SYNTH_ON = 3'h3;
  localparam logic [2:0] ST_CALIBRATE = 3'h4;
  localparam logic [2:0] ST_SETTLING = 3'h5;
  localparam logic [2:0] ST_UNDERFLOW = 3'h7;
  // Oscillator start-up time and its cycle count.
  localparam int OSC_START_US = 150;
  localparam int CLK_MHZ = 10;
  localparam int OSC_START_CYCLES = OSC_START_US * CLK_MHZ;
  // AXI4-Lite byte offsets.
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_IRQ_STATUS = 12'h008;
  localparam logic [11:0] A_IRQ_CLEAR = 12'h00c;
  localparam logic [11:0] A_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] A_BUF_POP = 12'h014;
  localparam logic [3:0] A_CFG_PAGE = 4'h1;
  // Control register fields.
  localparam int CTRL_SLEEP_BIT = 3;
  // Interrupt bit positions.
  localparam int IRQ_CFG_WR = 0;
  localparam int IRQ_BUF_WR = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_WIDTH = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Oscillator states, one-hot.
  typedef enum logic [2:0] {
    OSC_ON = 3'b001,
    OSC_OFF = 3'b010,
    OSC_WAKE = 3'b100
  } rcs_osc_t;
endpackage : rcs_pkg

//--- design/rcs_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain.
// Assumes the pins change slowly relative to aclk.
`timescale 1ns/1ns
module rcs_sync #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);
  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta;
  // Both stages reset high, the idle level of select and clock-free lines.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '1;
      sync <= '1;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule : rcs_sync

//--- design/rcs_spi_slave.sv
// Serial configuration port slave with register file, transmit buffer and AXI4-Lite access.
// Assumes sclk, select_low and si come from pins; the serial clock is far slower than aclk.
`timescale 1ns/1ns
module rcs_spi_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic select_low,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.
  logic [2:0] pins_s; // Synchronised {select_low, sclk, si}.
  logic sclk_d; // Previous synchronised clock level.
  logic sel_act; // Select asserted.
  logic sel_d; // Previous select state.
  logic sclk_rise;
  logic sclk_fall;
  logic si_s;
  rcs_sync #(.WIDTH(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({select_low, sclk, si}),
    .sync(pins_s)
  );
  assign sel_act = !pins_s[2];
  assign si_s = pins_s[0];
  assign sclk_rise = pins_s[1] && !sclk_d;
  assign sclk_fall = !pins_s[1] && sclk_d;
  // Edge history registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_d <= 1'b1;
      sel_d <= 1'b0;
    end
    else
    begin
      sclk_d <= pins_s[1];
      sel_d <= sel_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator power state.
  rcs_pkg::rcs_osc_t osc, next_osc;
  logic [10:0] osc_cnt, next_osc_cnt; // Start-up timer.
  logic sleep_req; // Software request to power down.
  logic osc_ready;
  assign osc_ready = (osc == rcs_pkg::OSC_ON);
  // Power-down only takes effect while deselected; select wakes the oscillator.
  always_comb
  begin
    next_osc = osc;
    next_osc_cnt = osc_cnt;
    case (osc)
      rcs_pkg::OSC_ON:
      begin
        if (sleep_req && !sel_act)
          next_osc = rcs_pkg::OSC_OFF;
      end
      rcs_pkg::OSC_OFF:
      begin
        next_osc_cnt = 11'h000;
        if (sel_act)
          next_osc = rcs_pkg::OSC_WAKE;
      end
      rcs_pkg::OSC_WAKE:
      begin
        // Serial-out stays high until the start-up time has run out.
        next_osc_cnt = osc_cnt + 11'h001; // RQ7
        if (osc_cnt == 11'(rcs_pkg::OSC_START_CYCLES - 1))
          next_osc = rcs_pkg::OSC_ON; // RQ7
      end
      default: next_osc = rcs_pkg::OSC_ON;
    endcase
  end
  // Oscillator registers; the chip comes out of reset with the oscillator running.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc <= rcs_pkg::OSC_ON;
      osc_cnt <= 11'h000;
    end
    else
    begin
      osc <= next_osc;
      osc_cnt <= next_osc_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and transmit buffer storage.
  logic [7:0] cfg_mem [rcs_pkg::CFG_COUNT];
  logic [7:0] buf_mem [rcs_pkg::BUF_DEPTH];
  logic [6:0] wp, rp; // Buffer pointers with wrap bit.
  logic [6:0] fill;
  logic [6:0] free_cnt;
  logic [3:0] free_sat;
  logic cfg_we, buf_push, buf_pop;
  logic [5:0] wr_addr;
  logic [7:0] wr_byte;
  logic [2:0] ctrl_state; // Main state code set by software.
  assign fill = wp - rp;
  assign free_cnt = 7'(rcs_pkg::BUF_DEPTH) - fill;
  assign free_sat = (free_cnt >= 7'h0f) ? rcs_pkg::FREE_SAT : free_cnt[3:0]; // RQ14
  // Storage writes; a reset restores every default so software need not.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < rcs_pkg::CFG_COUNT; i++)
        cfg_mem[i] <= rcs_pkg::CFG_RESET; // RQ9
      wp <= 7'h00;
      rp <= 7'h00;
    end
    else
    begin
      if (cfg_we)
        cfg_mem[wr_addr] <= wr_byte;
      if (buf_push)
      begin
        buf_mem[wp[5:0]] <= wr_byte; // RQ11
        wp <= wp + 7'h01;
      end
      if (buf_pop)
        rp <= rp + 7'h01;
    end
  end
  // Read view of a configuration address; anything else reads zero.
  function automatic logic [7:0] rcs_cfg_rd(input logic [5:0] a, input logic [7:0] m [rcs_pkg::CFG_COUNT]);
    rcs_cfg_rd = (a <= rcs_pkg::CFG_LAST) ? m[a] : 8'h00;
  endfunction : rcs_cfg_rd

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine.
  logic [2:0] bit_cnt, next_bit_cnt;
  logic in_hdr, next_in_hdr; // Next byte is a header.
  logic rw, next_rw;
  logic burst, next_burst;
  logic [5:0] addr, next_addr;
  logic [7:0] shin, next_shin;
  logic [7:0] shout, next_shout;
  logic next_so;
  logic abort_ev;
  logic [7:0] rx_byte;
  assign rx_byte = {shin[6:0], si_s};
  // Bits are taken on rising clock edges and shifted out on falling ones.
  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_in_hdr = in_hdr;
    next_rw = rw;
    next_burst = burst;
    next_addr = addr;
    next_shin = shin;
    next_shout = shout;
    cfg_we = 1'b0;
    buf_push = 1'b0;
    abort_ev = 1'b0;
    wr_addr = addr;
    wr_byte = rx_byte;
    if (!sel_act)
    begin
      // Release mid-byte drops the byte; nothing has been stored yet.
      abort_ev = sel_d && (bit_cnt != 3'h0); // RQ4
      next_bit_cnt = 3'h0; // RQ16
      next_in_hdr = 1'b1; // RQ16
    end
    else
    begin
      // Status byte is offered for headers and for write data.
      if (bit_cnt == 3'h0 && !sclk_rise && (in_hdr || !rw))
        next_shout = {!osc_ready, ctrl_state, free_sat}; // RQ12 RQ13 RQ14 RQ6
      // Clock edges before the oscillator runs are ignored.
      if (sclk_rise && osc_ready)
      begin
        next_shin = rx_byte; // RQ1
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          if (in_hdr)
          begin
            next_rw = rx_byte[rcs_pkg::HDR_RW]; // RQ2
            next_burst = rx_byte[rcs_pkg::HDR_BURST]; // RQ2
            next_addr = rx_byte[5:0]; // RQ2 RQ15
            // Strobes carry no data, so the next byte is again a header.
            next_in_hdr = !rx_byte[rcs_pkg::HDR_BURST] && rx_byte[5:0] >= rcs_pkg::STROBE_FIRST
              && rx_byte[5:0] <= rcs_pkg::STROBE_LAST;
            if (rx_byte[rcs_pkg::HDR_RW])
              next_shout = rcs_cfg_rd(rx_byte[5:0], cfg_mem);
          end
          else
          begin
            if (!rw && addr == rcs_pkg::BUF_ADDR)
              buf_push = (fill != 7'(rcs_pkg::BUF_DEPTH)); // RQ11
            else if (!rw)
              cfg_we = (addr <= rcs_pkg::CFG_LAST);
            next_in_hdr = !burst;
            if (burst)
            begin
              next_addr = addr + 6'h01; // RQ15
              if (rw)
                next_shout = rcs_cfg_rd(addr + 6'h01, cfg_mem);
            end
          end
        end
      end
      if (sclk_fall && bit_cnt != 3'h0)
        next_shout = {shout[6:0], 1'b0}; // RQ1
    end
    // Serial-out is forced high while the oscillator is not running.
    next_so = osc_ready ? shout[7] : 1'b1; // RQ7
  end
  // Serial engine registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_cnt <= 3'h0;
      in_hdr <= 1'b1;
      rw <= 1'b0;
      burst <= 1'b0;
      addr <= 6'h00;
      shin <= 8'h00;
      shout <= 8'hff;
      so <= 1'b1;
      so_oe_n <= 1'b1;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      in_hdr <= next_in_hdr;
      rw <= next_rw;
      burst <= next_burst;
      addr <= next_addr;
      shin <= next_shin;
      shout <= next_shout;
      so <= next_so;
      so_oe_n <= !sel_act; // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, interrupt and control registers.
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [11:0] aw_q, next_aw_q;
  logic [7:0] w_q, next_w_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [2:0] next_ctrl_state;
  logic [rcs_pkg::IRQ_WIDTH-1:0] irq_status, next_irq_status, irq_enable, next_irq_enable, irq_clr;
  logic next_sleep_req;
  logic do_wr;
  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign arready = !rvalid;
  assign do_wr = aw_hold && w_hold;
  assign irq = |(irq_status & irq_enable);
  // Address and data are captured separately; the write completes once both are held.
  always_comb
  begin
    next_aw_hold = aw_hold || (awvalid && awready);
    next_w_hold = w_hold || (wvalid && wready);
    next_aw_q = (awvalid && awready) ? awaddr : aw_q;
    next_w_q = (wvalid && wready) ? (wstrb[0] ? wdata[7:0] : 8'h00) : w_q;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_ctrl_state = ctrl_state;
    next_irq_enable = irq_enable;
    next_sleep_req = sleep_req && osc_ready;
    irq_clr = '0;
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    buf_pop = 1'b0;
    if (do_wr)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rcs_pkg::RESP_OKAY;
      case (aw_q)
        rcs_pkg::A_CTRL:
        begin
          next_ctrl_state = w_q[2:0];
          next_sleep_req = w_q[rcs_pkg::CTRL_SLEEP_BIT];
        end
        rcs_pkg::A_IRQ_CLEAR: irq_clr = w_q[rcs_pkg::IRQ_WIDTH-1:0];
        rcs_pkg::A_IRQ_ENABLE: next_irq_enable = w_q[rcs_pkg::IRQ_WIDTH-1:0];
        default: next_bresp = rcs_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = rcs_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (araddr[11:8] == rcs_pkg::A_CFG_PAGE && araddr[1:0] == 2'h0 && araddr[7:2] <= rcs_pkg::CFG_LAST)
        next_rdata = {24'h00_0000, cfg_mem[araddr[7:2]]};
      else
        case (araddr)
          rcs_pkg::A_CTRL: next_rdata = {28'h000_0000, sleep_req, ctrl_state};
          rcs_pkg::A_STATUS: next_rdata = {16'h0000, 1'b0, fill, 6'h00, !osc_ready, sel_act};
          rcs_pkg::A_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_status};
          rcs_pkg::A_IRQ_CLEAR: next_rdata = 32'h0000_0000;
          rcs_pkg::A_IRQ_ENABLE: next_rdata = {29'h0000_0000, irq_enable};
          rcs_pkg::A_BUF_POP:
          begin
            // Reading drains one byte; bit 8 tells whether the byte was real.
            buf_pop = (fill != 7'h00);
            // An empty read returns zero, never stale or unwritten storage.
            next_rdata = {23'h00_0000, buf_pop, buf_pop ? buf_mem[rp[5:0]] : 8'h00};
          end
          default: next_rresp = rcs_pkg::RESP_SLVERR;
        endcase
    end
    // A new event wins over a clear in the same cycle.
    next_irq_status = (irq_status & ~irq_clr) | {abort_ev, buf_push, cfg_we};
  end
  // Bus and control registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 8'h00;
      bvalid <= 1'b0;
      bresp <= rcs_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rcs_pkg::RESP_OKAY;
      ctrl_state <= rcs_pkg::ST_IDLE;
      sleep_req <= 1'b0;
      irq_status <= '0;
      irq_enable <= '0;
    end
    else
    begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl_state <= next_ctrl_state;
      sleep_req <= next_sleep_req;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_msb_first;
    sel_act && sclk_fall && bit_cnt != 3'h0 |=> shout[7] == $past(shout[6]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("serial out not msb first"); // RQ1
  property p_header;
    sel_act && sclk_rise && osc_ready && bit_cnt == 3'h7 && in_hdr
      |=> rw == $past(shin[6]) && burst == $past(shin[5]) && addr == {$past(shin[4:0]), $past(si_s)};
  endproperty
  a_header: assert property (p_header) else $error("header decoded wrongly"); // RQ2
  property p_abort;
    $fell(sel_act) |-> ##1 (in_hdr && bit_cnt == 3'h0) [*2];
  endproperty
  a_abort: assert property (p_abort) else $error("release did not reset the port"); // RQ4
  property p_ready_low;
    $rose(sel_act) && osc_ready && !sclk_rise |-> ##2 !so && !so_oe_n;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("serial out not low when ready"); // RQ6
  property p_wake_high;
    !osc_ready |=> so;
  endproperty
  a_wake_high: assert property (p_wake_high) else $error("serial out low before oscillator ready"); // RQ7
  property p_wake_time;
    $rose(osc == rcs_pkg::OSC_WAKE) |-> !osc_ready [*8] ##1 (osc_cnt >= 11'h008);
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("oscillator ready too early"); // RQ7
  property p_reset_default;
    @(posedge aclk) disable iff (1'b0) !aresetn |=> cfg_mem[0] == rcs_pkg::CFG_RESET && cfg_mem[46] == rcs_pkg::CFG_RESET;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("defaults not loaded"); // RQ9
  property p_buf_push;
    buf_push |=> wp == $past(wp) + 7'h01 && buf_mem[$past(wp[5:0])] == $past(rx_byte);
  endproperty
  a_buf_push: assert property (p_buf_push) else $error("buffer byte lost"); // RQ11
  property p_status;
    sel_act && bit_cnt == 3'h0 && !sclk_rise && in_hdr && osc_ready
      |=> shout == {1'b0, $past(ctrl_state), $past(free_sat)};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong"); // RQ12
  property p_free_sat;
    free_cnt >= 7'h0f ? free_sat == 4'hf : free_sat == free_cnt[3:0];
  endproperty
  a_free_sat: assert property (p_free_sat) else $error("free count not saturated"); // RQ14
  property p_burst_step;
    sel_act && sclk_rise && osc_ready && bit_cnt == 3'h7 && !in_hdr && burst |=> addr == $past(addr) + 6'h01;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst address did not step"); // RQ15
  property p_no_write_idle;
    !sel_act |-> !cfg_we && !buf_push;
  endproperty
  a_no_write_idle: assert property (p_no_write_idle) else $error("write while deselected"); // RQ16
  c_burst_write: cover property (cfg_we && burst);
  c_abort: cover property (abort_ev);
  c_wake: cover property (osc == rcs_pkg::OSC_WAKE ##1 osc_ready);
  c_buf: cover property (buf_push);
endmodule : rcs_spi_slave

//--- verif/rcs_host.sv
// Host controller model: drives the serial port as master, sampling on sclk rise.
// Assumes so is driven by the device while select_low is low.
`timescale 1ns/1ns
module rcs_host (
  output logic select_low,
  output logic sclk,
  output logic si,
  input wire logic so
);
  // Deselected, with the clock parked low between frames.
  initial
  begin
    select_low = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Select, then poll so for the ready level; waited returns ns spent.
  task automatic sel(output int waited);
    // Stay clear of aclk edges, and give the device time to take the line before polling it.
    #25;
    select_low = 1'b0;
    #500;
    waited = 500;
    while (so !== 1'b0 && waited < 400000)
    begin
      #100;
      waited += 100;
    end
  endtask : sel
  // Shift nbits of tx from the top down; low time 500 ns leaves room for the so delay.
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      si = tx[i];
      #500 sclk = 1'b1;
      rx[i] = so;
      #300 sclk = 0;
    end
    // Hold time is over, so the line shows a changing level, not the last bit.
    #100 si = ~si;
  endtask : xfer
  // Release select once the last falling edge is well past.
  task automatic desel();
    #200 select_low = 1'b1;
    #800;
  endtask : desel
endmodule : rcs_host

//--- verif/tb.sv
// Self-checking bench for the serial port slave and its AXI4-Lite registers.
// Assumes the host model drives the serial pins; the bench is the bus master.
`timescale 1ns/1ns
module tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, so, so_oe_n, irq, select_low, sclk, si;
  logic [1:0] bresp, rresp;
  // Undriven line has no pull, so the host sees the inverse of the last level.
  logic so_line;
  assign so_line = so_oe_n ? ~so : so;
  logic [31:0] rdata;
  int errors = 0, samples_checked = 0, w;
  string nm_q[$];
  logic [33:0] exp_q[$], obs_q[$];
  logic [7:0] rx, bd[52];
  logic [2:0] codes[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  // The clock toggles every half period of 50 ns.
  always #50 aclk = ~aclk;
  rcs_spi_slave dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .select_low(select_low), .sclk(sclk), .si(si), .so(so),
    .so_oe_n(so_oe_n), .irq(irq));
  rcs_host host (.select_low(select_low), .sclk(sclk), .si(si), .so(so_line));
  ////////////////////////////////////////////////////////////
  // Compare one result with its note and count it.
  task automatic check(input string nm, input logic [33:0] got, input logic [33:0] ex);
    samples_checked++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  // Queue an expectation together with what was seen.
  task automatic note(input string nm, input logic [33:0] ex, input logic [33:0] got);
    nm_q.push_back(nm);
    exp_q.push_back(ex);
    obs_q.push_back(got);
  endtask : note
  // The watcher takes the oldest note whenever a result is waiting.
  always @(posedge aclk)
    if (obs_q.size() > 0)
      check(nm_q.pop_front(), obs_q.pop_front(), exp_q.pop_front());
  // Write one word; ready is looked at mid-cycle, which equals its value at the next edge.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tk;
    logic [1:0] got;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      got = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (tk !== 1'b1);
    bready <= 1'b0;
    note("bresp", {32'h0, er}, {32'h0, got});
  endtask : axw
  // Read one word and compare response and data together.
  task automatic axr(input logic [11:0] a, input logic [33:0] ex, input string nm);
    logic ta, tk;
    logic [33:0] got;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tk = rvalid;
      got = {rresp, rdata};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    while (tk !== 1'b1);
    rready <= 1'b0;
    note(nm, ex, got);
  endtask : axr
  // One serial byte with the byte expected back on so.
  task automatic sx(input logic [7:0] tx, input logic [7:0] ex, input string nm);
    host.xfer(tx, 8, rx);
    note(nm, {26'h0, ex}, {26'h0, rx});
    note("so driven", 34'h0, {33'h0, so_oe_n});
  endtask : sx
  // Status byte: ready flag low, state code, free count saturated at 15.
  function automatic logic [7:0] st(input logic [2:0] c, input int fr);
    return {1'b0, c, (fr >= 15) ? 4'hf : 4'(fr)};
  endfunction : st
  // Byte address of configuration register n.
  function automatic logic [11:0] ca(input int n);
    return {rcs_pkg::A_CFG_PAGE, 8'h00} + 12'(4 * n);
  endfunction : ca
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // A hang past the expected run of some 11k cycles counts as a mismatch.
  initial
  begin
    #9000000;
    errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(91));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ca(7), 34'h0, "cfg default");
    axr(12'h0f0, {rcs_pkg::RESP_SLVERR, 32'h0}, "unmapped");
    axw(rcs_pkg::A_STATUS, 32'h1, rcs_pkg::RESP_SLVERR);
    axw(rcs_pkg::A_IRQ_ENABLE, 32'h7, rcs_pkg::RESP_OKAY);
    // Every state code, each with a single write that the host then reads back.
    foreach (codes[i])
    begin
      bd[i] = 8'($urandom);
      axw(rcs_pkg::A_CTRL, {29'h0, codes[i]}, rcs_pkg::RESP_OKAY);
      host.sel(w);
      note("ready wait", 34'h1, {33'h0, w < 2000});
      sx({2'b00, 6'(i)}, st(codes[i], 64), "hdr status");
      sx(bd[i], st(codes[i], 64), "data status");
      host.desel();
      axr(ca(i), {26'h0, bd[i]}, "cfg written");
      note("irq set", 34'h1, {33'h0, irq});
    end
    axw(rcs_pkg::A_IRQ_CLEAR, 32'h7, rcs_pkg::RESP_OKAY);
    @(negedge aclk);
    note("irq cleared", 34'h0, {33'h0, irq});
    axw(rcs_pkg::A_CTRL, 32'h0, rcs_pkg::RESP_OKAY);
    // Burst write three registers, then burst read them back.
    host.sel(w);
    sx(8'h4a, st(0, 64), "burst hdr");
    for (int k = 0; k < 3; k++) sx(bd[k], st(0, 64), "burst status");
    host.desel();
    host.sel(w);
    sx(8'hca, st(0, 64), "burst rd hdr");
    for (int k = 0; k < 3; k++) sx(8'h00, bd[k], "burst rd data");
    host.desel();
    // A strobe takes no data byte, so the next byte is a fresh header.
    host.sel(w);
    sx(8'h30, st(0, 64), "strobe hdr");
    sx(8'h0d, st(0, 64), "after strobe hdr");
    sx(8'h5a, st(0, 64), "after strobe data");
    host.desel();
    axr(ca(13), {26'h0, 8'h5a}, "strobe then write");
    // Select released after half a data byte: register stays, abort flagged.
    host.sel(w);
    sx(8'h0a, st(0, 64), "abort hdr");
    host.xfer(~bd[0], 4, rx);
    host.desel();
    axr(ca(10), {26'h0, bd[0]}, "abort kept");
    axr(rcs_pkg::A_IRQ_STATUS, 34'h5, "irq status");
    // Fill the transmit buffer below fifteen free bytes, then drain it.
    for (int i = 0; i < 52; i++)
    begin
      bd[i] = 8'($urandom);
      host.sel(w);
      sx(8'h3f, st(0, 64 - i), "buf hdr");
      sx(bd[i], st(0, 64 - i), "buf status");
      host.desel();
    end
    for (int i = 0; i < 52; i++) axr(rcs_pkg::A_BUF_POP, {25'h1, bd[i]}, "buf pop");
    axr(rcs_pkg::A_BUF_POP, 34'h0, "buf empty");
    // Power down, then the select must wake it through the full start-up.
    axw(rcs_pkg::A_CTRL, 32'h8, rcs_pkg::RESP_OKAY);
    repeat (10) @(posedge aclk);
    host.sel(w);
    note("wake wait", 34'h1, {33'h0, w >= rcs_pkg::OSC_START_CYCLES * 100});
    sx(8'h0b, st(0, 64), "wake status");
    host.desel();
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule : tb
